// ==== etc_pkg.sv ====
// Purpose: Constants and types shared by the event-driven transfer controller.
// Assumes: A 16-bit memory bus with byte addresses and a request held until acknowledged.
// Notes: Field positions of the mode words are fixed here and used by the controller.

package etc_pkg;

  localparam int NUM_SRC = 8;
  localparam logic [3:0] SRC_SOFTWARE = 4'h8;
  localparam logic [15:0] SW_VEC_BASE = 16'h0400;
  localparam logic [15:0] SRC_VEC_BASE = 16'h0420;
  localparam logic [7:0] VEC_PAGE = 8'h00;
  localparam logic [7:0] RAM_PAGE = 8'hff;
  localparam logic [2:0] SET_LAST_WORD = 3'h5;
  localparam logic [23:0] SET_BYTES = 24'h00_000c;

  localparam int MODE_A_SRC_POS = 6;
  localparam int MODE_A_DST_POS = 4;
  localparam int MODE_A_KIND_POS = 2;
  localparam int MODE_A_AREA_BIT = 1;
  localparam int MODE_A_WORD_BIT = 0;
  localparam int MODE_B_CHAIN_BIT = 7;
  localparam int MODE_B_EACH_BIT = 6;
  localparam int SW_ENABLE_BIT = 7;

  localparam logic [1:0] AM_INC = 2'h2;
  localparam logic [1:0] AM_DEC = 2'h3;
  localparam logic [1:0] MD_NORMAL = 2'h0;
  localparam logic [1:0] MD_REPEAT = 2'h1;
  localparam logic [1:0] MD_BLOCK = 2'h2;

  localparam logic [7:0] ENABLE_RST = 8'h00;
  localparam logic [7:0] SWVEC_RST = 8'h00;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_VEC,
    ST_FETCH,
    ST_READ,
    ST_WRITE,
    ST_BACK,
    ST_DONE
  } etc_state_type;

  typedef struct packed {
    logic [7:0] mode_word_a;
    logic [23:0] source_pointer;
    logic [7:0] mode_word_b;
    logic [23:0] destination_pointer;
    logic [15:0] count_word_a;
    logic [15:0] count_word_b;
  } etc_set_type;

  typedef struct packed {
    logic valid;
    logic write;
    logic byte_size;
    logic [23:0] addr;
    logic [15:0] wdata;
  } etc_mem_req_type;

  typedef struct packed {
    logic ack;
    logic [15:0] rdata;
  } etc_mem_rsp_type;

endpackage

// ==== etc_pair_buf.sv ====
// Purpose: Small FIFO that holds data words between the read and write phases.
// Assumes: One clock, synchronous active-low reset.
// Notes: Depth two by default; full and empty are exact.
`timescale 1ns/10ps
`default_nettype none

module etc_pair_buf #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 2
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);

  localparam int PW = $clog2(DEPTH);
  localparam logic [PW:0] FULL = DEPTH[PW:0];
  localparam logic [PW-1:0] LAST = PW'(DEPTH - 1);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [WIDTH-1:0] mem_d [DEPTH];
  logic [PW-1:0] wp_q, wp_d, rp_q, rp_d;
  logic [PW:0] cnt_q, cnt_d;
  logic push, pop;

  assign in_ready = cnt_q != FULL;
  assign out_valid = cnt_q != '0;
  assign out_data = mem_q[rp_q];
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;

  always_comb begin
    mem_d = mem_q;
    wp_d = wp_q;
    rp_d = rp_q;
    cnt_d = cnt_q;
    if (push) begin
      mem_d[wp_q] = in_data;
      wp_d = (wp_q == LAST) ? '0 : wp_q + 1'b1;
    end
    if (pop) begin
      rp_d = (rp_q == LAST) ? '0 : rp_q + 1'b1;
    end
    if (push && !pop) begin
      cnt_d = cnt_q + 1'b1;
    end else if (pop && !push) begin
      cnt_d = cnt_q - 1'b1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      wp_q <= '0;
      rp_q <= '0;
      cnt_q <= '0;
      for (int i = 0; i < DEPTH; i++) begin
        mem_q[i] <= '0;
      end
    end else begin
      wp_q <= wp_d;
      rp_q <= rp_d;
      cnt_q <= cnt_d;
      mem_q <= mem_d;
    end
  end

endmodule

`default_nettype wire

// ==== etc_transfer_controller.sv ====
// Purpose: Event-driven transfer controller that moves data using register sets kept in memory.
// Assumes: Peripheral request flags come from logic on the same clock; memory holds each
// Assumes: request until it acknowledges, with read data valid in the acknowledge cycle.
// Notes: Software source outranks all interrupt sources; lower source index outranks higher.
`timescale 1ns/10ps
`default_nettype none

module etc_transfer_controller (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic [etc_pkg::NUM_SRC-1:0] irq_req,
  input wire logic enable_wr,
  input wire logic [etc_pkg::NUM_SRC-1:0] enable_wdata,
  output logic [etc_pkg::NUM_SRC-1:0] per_source_enable_bits,
  input wire logic swvec_wr,
  input wire logic [7:0] swvec_wdata,
  output logic [7:0] software_vector_register,
  output logic [etc_pkg::NUM_SRC-1:0] cpu_irq_route,
  output logic sw_cpu_irq,
  output logic [etc_pkg::NUM_SRC-1:0] src_flag_clear,
  output logic busy,
  output etc_pkg::etc_mem_req_type mem_req,
  input wire etc_pkg::etc_mem_rsp_type mem_rsp
);

  function automatic logic [23:0] step_addr(input logic [23:0] a, input logic [1:0] am,
                                            input logic word);
    logic [23:0] s;
    s = word ? 24'h00_0002 : 24'h00_0001;
    if (am == etc_pkg::AM_INC) begin
      step_addr = a + s;
    end else if (am == etc_pkg::AM_DEC) begin
      step_addr = a - s;
    end else begin
      step_addr = a;
    end
  endfunction

  function automatic logic [23:0] back_addr(input logic [23:0] a, input logic [1:0] am,
                                            input logic [7:0] n, input logic word);
    logic [23:0] off;
    off = {15'h0000, (n == 8'h00), n} << word;
    if (am == etc_pkg::AM_INC) begin
      back_addr = a - off;
    end else if (am == etc_pkg::AM_DEC) begin
      back_addr = a + off;
    end else begin
      back_addr = a;
    end
  endfunction

  etc_pkg::etc_state_type state_q, state_d;
  logic [5:0][15:0] words_q, words_d;
  logic [2:0] idx_q, idx_d;
  logic [23:0] base_q, base_d;
  logic [23:0] vec_q, vec_d;
  logic [3:0] src_q, src_d;
  logic first_q, first_d;
  logic each_q, each_d;
  logic ended_q, ended_d;
  logic swpend_q, swpend_d;
  logic [etc_pkg::NUM_SRC-1:0] en_q, en_d;
  logic [7:0] swv_q, swv_d;
  logic [etc_pkg::NUM_SRC-1:0] route_q, route_d;
  logic swirq_q, swirq_d;
  logic [etc_pkg::NUM_SRC-1:0] fclr_q, fclr_d;

  logic buf_in_valid, buf_in_ready, buf_out_valid, buf_out_ready;
  logic [15:0] buf_out_data;

  etc_pkg::etc_set_type cur;
  etc_pkg::etc_set_type nxt;
  logic [1:0] sm, dm, md;
  logic dts, word, chain;
  logic [etc_pkg::NUM_SRC-1:0] pending;
  logic [23:0] word_addr;

  assign cur = words_q;
  assign sm = cur.mode_word_a[etc_pkg::MODE_A_SRC_POS +: 2];
  assign dm = cur.mode_word_a[etc_pkg::MODE_A_DST_POS +: 2];
  assign md = cur.mode_word_a[etc_pkg::MODE_A_KIND_POS +: 2];
  assign dts = cur.mode_word_a[etc_pkg::MODE_A_AREA_BIT];
  assign word = cur.mode_word_a[etc_pkg::MODE_A_WORD_BIT];
  assign chain = cur.mode_word_b[etc_pkg::MODE_B_CHAIN_BIT];
  assign word_addr = base_q + {20'h0_0000, idx_q, 1'b0};
  // Enabled sources start regardless of CPU mask or interrupt priority.
  assign pending = irq_req & en_q;

  assign per_source_enable_bits = en_q;
  assign software_vector_register = swv_q;
  assign cpu_irq_route = route_q;
  assign sw_cpu_irq = swirq_q;
  assign src_flag_clear = fclr_q;
  assign busy = state_q != etc_pkg::ST_IDLE;

  etc_pair_buf #(
    .WIDTH(16),
    .DEPTH(2)
  ) u_buf (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .in_valid(buf_in_valid),
    .in_ready(buf_in_ready),
    .in_data(mem_rsp.rdata),
    .out_valid(buf_out_valid),
    .out_ready(buf_out_ready),
    .out_data(buf_out_data)
  );

  always_comb begin
    state_d = state_q;
    words_d = words_q;
    idx_d = idx_q;
    base_d = base_q;
    vec_d = vec_q;
    src_d = src_q;
    first_d = first_q;
    each_d = each_q;
    ended_d = ended_q;
    swpend_d = swpend_q;
    en_d = en_q;
    swv_d = swv_q;
    swirq_d = 1'b0;
    fclr_d = '0;
    nxt = cur;
    mem_req = '0;
    buf_in_valid = 1'b0;
    buf_out_ready = 1'b0;
    route_d = irq_req & ~en_q;
    unique case (state_q)
      etc_pkg::ST_IDLE: begin
        first_d = 1'b1;
        if (swpend_q) begin
          swpend_d = 1'b0;
          src_d = etc_pkg::SRC_SOFTWARE;
          vec_d = {etc_pkg::VEC_PAGE, etc_pkg::SW_VEC_BASE + {8'h00, swv_q[6:0], 1'b0}};
          state_d = etc_pkg::ST_VEC;
        end else if (|pending) begin
          for (int i = etc_pkg::NUM_SRC - 1; i >= 0; i--) begin
            if (pending[i]) begin
              src_d = 4'(i);
            end
          end
          vec_d = {etc_pkg::VEC_PAGE, etc_pkg::SRC_VEC_BASE + {11'h000, src_d, 1'b0}};
          state_d = etc_pkg::ST_VEC;
        end
      end
      etc_pkg::ST_VEC: begin
        mem_req.valid = 1'b1;
        mem_req.addr = vec_q;
        if (mem_rsp.ack) begin
          base_d = {etc_pkg::RAM_PAGE, mem_rsp.rdata};
          idx_d = '0;
          state_d = etc_pkg::ST_FETCH;
        end
      end
      etc_pkg::ST_FETCH: begin
        mem_req.valid = 1'b1;
        mem_req.addr = word_addr;
        if (mem_rsp.ack) begin
          words_d[3'(etc_pkg::SET_LAST_WORD - idx_q)] = mem_rsp.rdata;
          idx_d = idx_q + 1'b1;
          if (idx_q == etc_pkg::SET_LAST_WORD) begin
            idx_d = '0;
            state_d = etc_pkg::ST_READ;
          end
        end
      end
      etc_pkg::ST_READ: begin
        mem_req.valid = buf_in_ready;
        mem_req.byte_size = !word;
        mem_req.addr = cur.source_pointer;
        if (buf_in_ready && mem_rsp.ack) begin
          buf_in_valid = 1'b1;
          state_d = etc_pkg::ST_WRITE;
        end
      end
      etc_pkg::ST_WRITE: begin
        mem_req.valid = buf_out_valid;
        mem_req.write = 1'b1;
        mem_req.byte_size = !word;
        mem_req.addr = cur.destination_pointer;
        mem_req.wdata = buf_out_data;
        if (buf_out_valid && mem_rsp.ack) begin
          buf_out_ready = 1'b1;
          nxt.source_pointer = step_addr(cur.source_pointer, sm, word);
          nxt.destination_pointer = step_addr(cur.destination_pointer, dm, word);
          nxt.count_word_a[7:0] = cur.count_word_a[7:0] - 8'h01;
          state_d = etc_pkg::ST_BACK;
          if (md == etc_pkg::MD_NORMAL || md == 2'h3) begin
            nxt.count_word_a = cur.count_word_a - 16'h0001;
            ended_d = nxt.count_word_a == 16'h0000;
          end else if (cur.count_word_a[7:0] == 8'h01) begin
            nxt.count_word_a[7:0] = cur.count_word_a[15:8];
            if (dts) begin
              nxt.source_pointer = back_addr(nxt.source_pointer, sm,
                                             cur.count_word_a[15:8], word);
            end else begin
              nxt.destination_pointer = back_addr(nxt.destination_pointer, dm,
                                                  cur.count_word_a[15:8], word);
            end
            ended_d = 1'b0;
            if (md == etc_pkg::MD_BLOCK) begin
              nxt.count_word_b = cur.count_word_b - 16'h0001;
              ended_d = nxt.count_word_b == 16'h0000;
            end
          end else begin
            ended_d = 1'b0;
            if (md == etc_pkg::MD_BLOCK) begin
              state_d = etc_pkg::ST_READ;
            end
          end
          if (!first_q) begin
            ended_d = ended_q;
          end
          each_d = first_q ? cur.mode_word_b[etc_pkg::MODE_B_EACH_BIT] : each_q;
          words_d = nxt;
          idx_d = '0;
        end
      end
      etc_pkg::ST_BACK: begin
        mem_req.valid = 1'b1;
        mem_req.write = 1'b1;
        mem_req.addr = word_addr;
        mem_req.wdata = words_q[3'(etc_pkg::SET_LAST_WORD - idx_q)];
        if (mem_rsp.ack) begin
          idx_d = idx_q + 1'b1;
          if (idx_q == etc_pkg::SET_LAST_WORD) begin
            idx_d = '0;
            if (chain) begin
              base_d = base_q + etc_pkg::SET_BYTES;
              first_d = 1'b0;
              state_d = etc_pkg::ST_FETCH;
            end else begin
              state_d = etc_pkg::ST_DONE;
              if (src_q == etc_pkg::SRC_SOFTWARE) begin
                if (!each_q && !ended_q) begin
                  swv_d[etc_pkg::SW_ENABLE_BIT] = 1'b0;
                end else begin
                  swirq_d = 1'b1;
                end
              end else if (!each_q && !ended_q) begin
                fclr_d[src_q[2:0]] = 1'b1;
              end else begin
                en_d[src_q[2:0]] = 1'b0;
              end
            end
          end
        end
      end
      etc_pkg::ST_DONE: begin
        state_d = etc_pkg::ST_IDLE;
      end
    endcase
    if (enable_wr) begin
      en_d = enable_wdata;
    end
    if (swvec_wr) begin
      swv_d = swvec_wdata;
      if (swvec_wdata[etc_pkg::SW_ENABLE_BIT]) begin
        swpend_d = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      state_q <= etc_pkg::ST_IDLE;
      words_q <= '0;
      idx_q <= '0;
      base_q <= '0;
      vec_q <= '0;
      src_q <= '0;
      first_q <= 1'b1;
      each_q <= 1'b0;
      ended_q <= 1'b0;
      swpend_q <= 1'b0;
      en_q <= etc_pkg::ENABLE_RST;
      swv_q <= etc_pkg::SWVEC_RST;
      route_q <= '0;
      swirq_q <= 1'b0;
      fclr_q <= '0;
    end else begin
      state_q <= state_d;
      words_q <= words_d;
      idx_q <= idx_d;
      base_q <= base_d;
      vec_q <= vec_d;
      src_q <= src_d;
      first_q <= first_d;
      each_q <= each_d;
      ended_q <= ended_d;
      swpend_q <= swpend_d;
      en_q <= en_d;
      swv_q <= swv_d;
      route_q <= route_d;
      swirq_q <= swirq_d;
      fclr_q <= fclr_d;
    end
  end

endmodule

`default_nettype wire

// ==== etc_monitor.sv ====
// Purpose: Port-level checks for the transfer controller.
// Assumes: Bound to the top module; one clock domain.
// Notes: Pulses and routing are tied to their causes.
`timescale 1ns/10ps
`default_nettype none
module etc_monitor (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic [etc_pkg::NUM_SRC-1:0] irq_req,
  input wire logic enable_wr,
  input wire logic [etc_pkg::NUM_SRC-1:0] per_source_enable_bits,
  input wire logic [7:0] software_vector_register,
  input wire logic [etc_pkg::NUM_SRC-1:0] cpu_irq_route,
  input wire logic sw_cpu_irq,
  input wire logic [etc_pkg::NUM_SRC-1:0] src_flag_clear,
  input wire logic busy,
  input wire etc_pkg::etc_mem_req_type mem_req,
  input wire etc_pkg::etc_mem_rsp_type mem_rsp
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  logic pulse;
  logic wr_done;
  logic [etc_pkg::NUM_SRC-1:0] route_d;
  assign pulse = sw_cpu_irq || (|src_flag_clear);
  assign wr_done = mem_req.valid && mem_req.write && mem_rsp.ack;
  assign route_d = irq_req & ~per_source_enable_bits;
  a_req_held: assert property (mem_req.valid && !mem_rsp.ack |=> $stable(mem_req))
    else $error("memory request changed before acknowledge");
  a_start_vector: assert property ($rose(busy) |-> mem_req.valid &&
    !mem_req.write && mem_req.addr[23:8] == 16'h0004)
    else $error("activation did not begin with a vector read");
  a_pulse_cause: assert property (pulse |-> busy && $past(wr_done))
    else $error("end pulse without a preceding write-back");
  a_pulse_idle: assert property (pulse |=> !busy && !pulse)
    else $error("end pulse not followed by idle");
  a_route_cpu: assert property ($past(rst_n) |-> cpu_irq_route == $past(route_d))
    else $error("cpu routing differs from disabled requests");
  a_sw_kept: assert property (sw_cpu_irq |->
    software_vector_register[etc_pkg::SW_ENABLE_BIT])
    else $error("software enable lost while interrupt raised");
  a_flag_kept: assert property ((src_flag_clear & ~per_source_enable_bits) == 8'h00)
    else $error("flag cleared for a source whose enable dropped");
  a_one_source: assert property ($onehot0(src_flag_clear) &&
    !(sw_cpu_irq && (|src_flag_clear)))
    else $error("more than one source finished at once");
  a_enable_end: assert property ($past(rst_n) && !$past(enable_wr) &&
    per_source_enable_bits != $past(per_source_enable_bits) |-> $past(busy))
    else $error("enable bits changed outside an activation");
  a_word_even: assert property (mem_req.valid && !mem_req.byte_size |-> !mem_req.addr[0])
    else $error("word access at odd address");
  c_sw_irq: cover property (sw_cpu_irq);
  c_flag: cover property (|src_flag_clear);
  c_start: cover property ($rose(busy));
endmodule
`default_nettype wire

// ==== etc_mem_model.sv ====
// Purpose: Memory partner that answers requests promptly or slowly.
// Assumes: Halfword storage; read data valid in the acknowledge cycle.
// Notes: Read data shows inverted junk outside acknowledge cycles.
`timescale 1ns/10ps
`default_nettype none
module etc_mem_model (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic slow,
  input wire etc_pkg::etc_mem_req_type mem_req,
  output etc_pkg::etc_mem_rsp_type mem_rsp
);
  logic [15:0] store [logic [22:0]];
  logic tick;
  initial mem_rsp = '0;
  initial tick = 1'b0;
  always @(posedge clk_sys) begin
    tick <= !tick;
    if (mem_req.valid && mem_rsp.ack && mem_req.write) begin
      store[mem_req.addr[23:1]] = mem_req.wdata;
    end
    if (!rst_n || mem_rsp.ack || !mem_req.valid || (slow && tick)) begin
      mem_rsp <= '{ack: 1'b0, rdata: ~mem_rsp.rdata};
    end else begin
      mem_rsp <= '{ack: 1'b1, rdata: store[mem_req.addr[23:1]]};
    end
  end
endmodule
`default_nettype wire

// ==== etc_transfer_controller_tb.sv ====
// Purpose: Self-checking bench for the transfer controller.
// Assumes: Word transfers in normal and block mode.
// Notes: Expected memory writes are queued and matched as they occur.
`timescale 1ns/10ps
`default_nettype none
module etc_transfer_controller_tb;
  logic clk_sys;
  logic rst_n;
  logic slow;
  logic [7:0] irq_req;
  logic [7:0] irq_raise;
  logic enable_wr;
  logic [7:0] enable_wdata;
  logic swvec_wr;
  logic [7:0] swvec_wdata;
  logic [7:0] per_source_enable_bits;
  logic [7:0] software_vector_register;
  logic [7:0] cpu_irq_route;
  logic sw_cpu_irq;
  logic [7:0] src_flag_clear;
  logic busy;
  logic sw;
  logic [7:0] fl;
  etc_pkg::etc_mem_req_type mem_req;
  etc_pkg::etc_mem_rsp_type mem_rsp;
  logic [39:0] exp_q [$];
  int err_count = 0;
  int comparisons = 0;
  int seed = 32'hffec46c3;
  always #2.5 clk_sys = !clk_sys;
  etc_transfer_controller DUT (.clk_sys(clk_sys), .rst_n(rst_n), .irq_req(irq_req),
    .enable_wr(enable_wr), .enable_wdata(enable_wdata),
    .per_source_enable_bits(per_source_enable_bits), .swvec_wr(swvec_wr),
    .swvec_wdata(swvec_wdata), .software_vector_register(software_vector_register),
    .cpu_irq_route(cpu_irq_route), .sw_cpu_irq(sw_cpu_irq),
    .src_flag_clear(src_flag_clear), .busy(busy), .mem_req(mem_req), .mem_rsp(mem_rsp));
  etc_mem_model mem (.clk_sys(clk_sys), .rst_n(rst_n), .slow(slow), .mem_req(mem_req),
    .mem_rsp(mem_rsp));
  task automatic stop_test();
    $display("comparisons %0d err_count %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic check(input logic [47:0] seen, input logic [47:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  function automatic logic [23:0] step(input logic [1:0] m);
    if (m == etc_pkg::AM_INC) return 24'h00_0002;
    return (m == etc_pkg::AM_DEC) ? 24'hff_fffe : 24'h00_0000;
  endfunction
  task automatic put(input logic [23:0] a, input logic [15:0] d);
    mem.store[a[23:1]] = d;
  endtask
  // Stores one set with its source word and queues the writes it must cause.
  task automatic plant(input logic [15:0] s, input logic [7:0] ma, input logic [23:0] sp,
    input logic [7:0] mb, input logic [23:0] dp, input logic [15:0] ca);
    logic [15:0] w [6];
    logic [23:0] a;
    logic [15:0] d;
    a = {etc_pkg::RAM_PAGE, s};
    d = 16'($random(seed));
    w = '{{ma, sp[23:16]}, sp[15:0], {mb, dp[23:16]}, dp[15:0], ca, 16'h0000};
    for (int i = 0; i < 6; i++) put(a + 24'(2 * i), w[i]);
    put(sp, d);
    exp_q.push_back({dp, d});
    sp = sp + step(ma[7:6]);
    dp = dp + step(ma[5:4]);
    w = '{{ma, sp[23:16]}, sp[15:0], {mb, dp[23:16]}, dp[15:0], ca - 16'h0001, 16'h0000};
    for (int i = 0; i < 6; i++) exp_q.push_back({a + 24'(2 * i), w[i]});
  endtask
  task automatic run(output logic swo, output logic [7:0] flo);
    int n;
    swo = 1'b0;
    flo = 8'h00;
    for (n = 0; n < 400 && !(n > 3 && busy === 1'b0); n++) begin
      @(posedge clk_sys);
      #1;
      swo = swo | sw_cpu_irq;
      flo = flo | src_flag_clear;
    end
    if (n == 400) begin
      err_count++;
      stop_test();
    end
  endtask
  // Two-word block from a source area that is restored, started by software.
  task automatic block_run();
    logic [15:0] w [6];
    logic [15:0] d [2];
    w = '{16'habff, 16'hf9c0, 16'h00ff, 16'hfac0, 16'h0202, 16'h0001};
    put(24'h00_0404, 16'hf860);
    for (int i = 0; i < 6; i++) put(24'hff_f860 + 24'(2 * i), w[i]);
    for (int i = 0; i < 2; i++) begin
      d[i] = 16'($random(seed));
      put(24'hff_f9c0 + 24'(2 * i), d[i]);
      exp_q.push_back({24'hff_fac0 + 24'(2 * i), d[i]});
    end
    w[3] = 16'hfac4;
    w[5] = 16'h0000;
    for (int i = 0; i < 6; i++) exp_q.push_back({24'hff_f860 + 24'(2 * i), w[i]});
    @(posedge clk_sys);
    swvec_wr <= 1'b1;
    swvec_wdata <= 8'h82;
    @(posedge clk_sys);
    swvec_wr <= 1'b0;
    run(sw, fl);
    check(sw, 1'b1);
    check(software_vector_register, 8'h82);
    $display("block activation done");
  endtask
  // The peripheral raises flags when asked and drops them when told.
  always @(posedge clk_sys) begin
    irq_req <= rst_n ? ((irq_req | irq_raise) & ~src_flag_clear) : 8'h00;
    if (mem_req.valid && mem_req.write && mem_rsp.ack) begin
      if (exp_q.size() == 0) check(48'h0000_0000_0001, 48'h0000_0000_0000);
      else check({mem_req.addr, mem_req.wdata}, exp_q.pop_front());
    end
  end
  initial begin
    clk_sys = 1'b0;
    rst_n = 1'b0;
    slow = 1'b0;
    irq_raise = 8'h00;
    enable_wr = 1'b0;
    enable_wdata = 8'h00;
    swvec_wr = 1'b0;
    swvec_wdata = 8'h00;
    repeat (4) @(posedge clk_sys);
    rst_n <= 1'b1;
    @(posedge clk_sys);
    #1;
    check(per_source_enable_bits, etc_pkg::ENABLE_RST);
    check(software_vector_register, etc_pkg::SWVEC_RST);
    put(24'h00_0402, 16'hf800);
    for (int k = 0; k < 3; k++) begin
      plant(16'hf800, 8'hb1, 24'hff_f900 + 24'(2 * k), 8'h00, 24'hff_fa00 - 24'(2 * k),
        16'(3 - k));
      @(posedge clk_sys);
      slow <= k[0];
      swvec_wr <= 1'b1;
      swvec_wdata <= 8'h81;
      @(posedge clk_sys);
      swvec_wr <= 1'b0;
      run(sw, fl);
      check(sw, k == 2);
      check(software_vector_register, (k == 2) ? 8'h81 : 8'h01);
      $display("software activation %0d done", k);
    end
    block_run();
    put(24'h00_0424, 16'hf810);
    put(24'h00_042a, 16'hf840);
    plant(16'hf810, 8'ha1, 24'hff_f980, 8'h80, 24'hff_fa80, 16'h0005);
    plant(16'hf81c, 8'h01, 24'hff_f990, 8'h00, 24'hff_fa90, 16'h0001);
    plant(16'hf840, 8'h81, 24'hff_f9a0, 8'h40, 24'hff_faa0, 16'h0004);
    @(posedge clk_sys);
    enable_wr <= 1'b1;
    enable_wdata <= 8'h24;
    irq_raise <= 8'ha4;
    @(posedge clk_sys);
    enable_wr <= 1'b0;
    irq_raise <= 8'h00;
    run(sw, fl);
    check(fl, 8'h04);
    check(per_source_enable_bits, 8'h24);
    run(sw, fl);
    check(fl, 8'h00);
    check(per_source_enable_bits, 8'h04);
    check(cpu_irq_route, 8'ha0);
    $display("interrupt activations done");
    check(exp_q.size(), 0);
    stop_test();
  end
endmodule
bind etc_transfer_controller etc_monitor chk (.clk_sys(clk_sys), .rst_n(rst_n),
  .irq_req(irq_req), .enable_wr(enable_wr), .per_source_enable_bits(per_source_enable_bits),
  .software_vector_register(software_vector_register), .cpu_irq_route(cpu_irq_route),
  .sw_cpu_irq(sw_cpu_irq), .src_flag_clear(src_flag_clear), .busy(busy),
  .mem_req(mem_req), .mem_rsp(mem_rsp));
`default_nettype wire
